// ==== eq_adapt_regs_map.svh ====
// Purpose: Offsets, field positions, reset values and scales of the equalizer adaptation registers
// Assumes: Byte-wide registers at the printed offsets
// Notes: Definitions only
`ifndef EQ_ADAPT_REGS_MAP_SVH
`define EQ_ADAPT_REGS_MAP_SVH

`define OFS_LOCK_QUAL 8'h2F
`define OFS_CDR_IRQ_AND_PATTERN_CTRL 8'h30
`define OFS_ADAPTATION_MODE_SELECT 8'h31
`define OFS_EYE_INTERRUPT_THRESHOLDS 8'h32
`define OFS_HANDOFF_THRESHOLDS 8'h33
`define OFS_LOCK_COUNT_AND_TAP_LIMIT 8'h34
`define OFS_OFFSET_REQUEST_AND_TAP1_LIMIT 8'h35
`define OFS_EYE_IRQ_ENABLE_AND_CAP_RANGE 8'h36
`define OFS_LINEAR_EQ_STATUS 8'h37
`define OFS_FEEDBACK_EQ_STATUS 8'h38

`define RST_LOCK_QUAL 8'h06
`define RST_CDR_IRQ_AND_PATTERN_CTRL 8'h00
`define RST_ADAPTATION_MODE_SELECT 8'h40
`define RST_EYE_INTERRUPT_THRESHOLDS 8'h11
`define RST_HANDOFF_THRESHOLDS 8'h88
`define RST_LOCK_COUNT_AND_TAP_LIMIT 8'h3F
`define RST_OFFSET_REQUEST_AND_TAP1_LIMIT 8'h1F
`define RST_EYE_IRQ_ENABLE_AND_CAP_RANGE 8'h33

`define BIT_PPM_CHECK_EN 2
`define BIT_FLD_CHECK_EN 1
`define BIT_CDR_IRQ_SEEN 4
`define BIT_PATTERN_CLK_EN 3
`define BIT_OFFSET_READY 7
`define BIT_LOW_POWER_DIS 6
`define BIT_OFFSET_REQ 5
`define BIT_EYE_IRQ_EN 6
`define BIT_CAP_OVR_EN 2

`define EYE_IRQ_SHIFT 2
`define HANDOFF_SHIFT 1

`endif

// ==== eq_adapt_pkg.sv ====
// Purpose: Types for the equalizer adaptation register bank
// Assumes: Eight-bit eye measurements, signed tap words
// Notes: Constants live in eq_adapt_regs_map.svh
package eq_adapt_pkg;

    typedef logic signed [7:0] tap_word_t;

    typedef struct packed {
        logic fld_check_en;
        logic ppm_check_en;
        logic pattern_clk_en;
        logic [1:0] pattern_sel;
        logic cdr_irq_seen;
        logic mode_res7;
        logic [1:0] adapt_mode;
        logic [1:0] fom_sel;
        logic [3:0] eye_h_thr;
        logic [3:0] eye_v_thr;
        logic [3:0] ho_h_thr;
        logic [3:0] ho_v_thr;
        logic offset_ready;
        logic low_power_dis;
        logic [1:0] lock_count;
        logic [3:0] tap25_max;
        logic [1:0] req_res76;
        logic offset_req;
        logic [4:0] tap1_max;
        logic irq_res7;
        logic eye_irq_en;
        logic [1:0] irq_res54;
        logic irq_res3;
        logic cap_ovr_en;
        logic [1:0] cap_range;
        logic [7:0] leq_status;
        logic [7:0] dfe_status;
        logic [2:0] cdr_sync;
        logic cdr_level;
        logic [7:0] rdata;
        logic eye_irq;
        logic handoff_ok;
        logic lock;
        logic [1:0] cap_range_out;
        logic [5:0] tap1_out;
        logic [19:0] tap25_out;
    } state_t;

endpackage

// ==== eq_adapt_regs.sv ====
// Purpose: Control and status registers that steer equalizer adaptation of one retimer channel
// Assumes: Byte register port from the management interface; eye, tap and status inputs on I_CLK
// Notes: Reads return data one cycle after the read strobe; only the CDR interrupt and the active-low reset are asynchronous
//
// Notes on behaviour
// R1: Two-bit mode picks adaptation sequence: off, linear only, linear-feedback-linear, lock variant; default 10.
// R2: Two-bit merit field: 00/11 both openings, 01 horizontal only, 10 vertical only.
// R3: Horizontal opening below four times upper threshold nibble flags eye interrupt, default 0001.
// R4: Vertical opening below four times lower threshold nibble flags eye interrupt, default 0001.
// R5: Handoff to feedback adaptation needs horizontal opening at least twice upper nibble, default 1000.
// R6: Handoff also needs vertical opening at least twice lower nibble, default 1000.
// R7: Read-only bit 4 goes high when the recovery loop raises its interrupt.
// R8: Writing one requests offset error; bit self-clears when done and ready bit 7 sets.
// R9: First feedback tap magnitude is clamped to a five-bit maximum, default 11111.
// R10: Feedback taps two to five are clamped to a four-bit maximum, default 1111.
// R11: Frequency lock detector result qualifies lock when its enable bit is set, default 1.
// R12: Bit 3 enables the pattern generator clock; bits 1:0 select the pattern.
// R13: Override enable in bit 2 forces the programmed oscillator capacitor range, default 11.
// R14: Frequency offset check qualifies lock when its enable bit is set, default 1.
// R15: Eye interrupt is a level: enabled and an opening below threshold, until recovery.
// R16: Linear and feedback status registers show adaptation results and ignore writes.
`timescale 1ns/1ps
`include "eq_adapt_regs_map.svh"

module eq_adapt_regs (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_CE,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WE,
    input wire logic I_REG_RE,
    output logic [7:0] O_REG_RDATA,
    input wire logic [7:0] I_HORIZONTAL_EYE_OPENING,
    input wire logic [7:0] I_VERTICAL_EYE_OPENING,
    input wire logic I_CDR_IRQ,
    input wire logic I_OFFSET_DONE,
    input wire logic I_CDR_LOCK_RAW,
    input wire logic I_FREQUENCY_LOCK_DETECTOR_OK,
    input wire logic I_FREQUENCY_OFFSET_OK,
    input wire logic [1:0] I_CAP_RANGE_AUTO,
    input wire logic [7:0] I_LINEAR_EQUALIZER_STATUS,
    input wire logic [7:0] I_DECISION_FEEDBACK_EQ_STATUS,
    input wire logic [5:0] I_TAP1_RAW,
    input wire logic [19:0] I_TAP25_RAW,
    output logic [1:0] O_ADAPT_MODE,
    output logic [1:0] O_FOM_SEL,
    output logic O_EYE_IRQ,
    output logic O_HANDOFF_OK,
    output logic O_FREQUENCY_OFFSET_REQ,
    output logic O_LOCK,
    output logic O_PATTERN_CLK_EN,
    output logic [1:0] O_PATTERN_SEL,
    output logic [1:0] O_CAP_RANGE,
    output logic [1:0] O_LOCK_COUNT,
    output logic O_LOW_POWER_DIS,
    output logic [5:0] O_TAP1,
    output logic [19:0] O_TAP25
);

    localparam eq_adapt_pkg::state_t RST_STATE = '{
        fld_check_en: 1'(`RST_LOCK_QUAL >> `BIT_FLD_CHECK_EN),
        ppm_check_en: 1'(`RST_LOCK_QUAL >> `BIT_PPM_CHECK_EN),
        pattern_clk_en: 1'(`RST_CDR_IRQ_AND_PATTERN_CTRL >> `BIT_PATTERN_CLK_EN),
        pattern_sel: 2'(`RST_CDR_IRQ_AND_PATTERN_CTRL),
        cdr_irq_seen: 1'b0,
        mode_res7: 1'b0,
        adapt_mode: 2'(`RST_ADAPTATION_MODE_SELECT >> 5),
        fom_sel: 2'(`RST_ADAPTATION_MODE_SELECT >> 3),
        eye_h_thr: 4'(`RST_EYE_INTERRUPT_THRESHOLDS >> 4),
        eye_v_thr: 4'(`RST_EYE_INTERRUPT_THRESHOLDS),
        ho_h_thr: 4'(`RST_HANDOFF_THRESHOLDS >> 4),
        ho_v_thr: 4'(`RST_HANDOFF_THRESHOLDS),
        offset_ready: 1'b0,
        low_power_dis: 1'(`RST_LOCK_COUNT_AND_TAP_LIMIT >> `BIT_LOW_POWER_DIS),
        lock_count: 2'(`RST_LOCK_COUNT_AND_TAP_LIMIT >> 4),
        tap25_max: 4'(`RST_LOCK_COUNT_AND_TAP_LIMIT),
        req_res76: 2'b00,
        offset_req: 1'b0,
        tap1_max: 5'(`RST_OFFSET_REQUEST_AND_TAP1_LIMIT),
        irq_res7: 1'b0,
        eye_irq_en: 1'(`RST_EYE_IRQ_ENABLE_AND_CAP_RANGE >> `BIT_EYE_IRQ_EN),
        irq_res54: 2'(`RST_EYE_IRQ_ENABLE_AND_CAP_RANGE >> 4),
        irq_res3: 1'b0,
        cap_ovr_en: 1'(`RST_EYE_IRQ_ENABLE_AND_CAP_RANGE >> `BIT_CAP_OVR_EN),
        cap_range: 2'(`RST_EYE_IRQ_ENABLE_AND_CAP_RANGE),
        leq_status: 8'h00,
        dfe_status: 8'h00,
        cdr_sync: 3'h0,
        cdr_level: 1'b0,
        rdata: 8'h00,
        eye_irq: 1'b0,
        handoff_ok: 1'b0,
        lock: 1'b0,
        cap_range_out: 2'h0,
        tap1_out: 6'h00,
        tap25_out: 20'h0_0000
    };

    // Scaled threshold: the nibble shifted left by one (x2) or two (x4)
    function automatic logic [7:0] scaled(input logic [3:0] thr, input logic two_bits);
        scaled = two_bits ? {2'b00, thr, 2'b00} : {3'b000, thr, 1'b0};
    endfunction

    // Clamp a signed tap so its magnitude does not pass the limit
    function automatic eq_adapt_pkg::tap_word_t clamp_tap(input eq_adapt_pkg::tap_word_t v,
                                                          input logic [4:0] lim);
        eq_adapt_pkg::tap_word_t pos;
        eq_adapt_pkg::tap_word_t neg;
        pos = $signed({3'b000, lim});
        neg = -pos;
        if (v > pos) begin
            clamp_tap = pos;
        end else if (v < neg) begin
            clamp_tap = neg;
        end else begin
            clamp_tap = v;
        end
    endfunction

    // One-hot register select: bit n stands for offset 0x2F + n, unmapped offsets give zero
    function automatic logic [9:0] reg_select(input logic [7:0] a);
        reg_select = 10'h000;
        if (a == `OFS_LOCK_QUAL) begin
            reg_select[0] = 1'b1;
        end else if (a == `OFS_CDR_IRQ_AND_PATTERN_CTRL) begin
            reg_select[1] = 1'b1;
        end else if (a == `OFS_ADAPTATION_MODE_SELECT) begin
            reg_select[2] = 1'b1;
        end else if (a == `OFS_EYE_INTERRUPT_THRESHOLDS) begin
            reg_select[3] = 1'b1;
        end else if (a == `OFS_HANDOFF_THRESHOLDS) begin
            reg_select[4] = 1'b1;
        end else if (a == `OFS_LOCK_COUNT_AND_TAP_LIMIT) begin
            reg_select[5] = 1'b1;
        end else if (a == `OFS_OFFSET_REQUEST_AND_TAP1_LIMIT) begin
            reg_select[6] = 1'b1;
        end else if (a == `OFS_EYE_IRQ_ENABLE_AND_CAP_RANGE) begin
            reg_select[7] = 1'b1;
        end else if (a == `OFS_LINEAR_EQ_STATUS) begin
            reg_select[8] = 1'b1;
        end else if (a == `OFS_FEEDBACK_EQ_STATUS) begin
            reg_select[9] = 1'b1;
        end
    endfunction

    eq_adapt_pkg::state_t s_q;
    eq_adapt_pkg::state_t s_d;

    always_comb begin
        logic h_low;
        logic v_low;
        logic wr;
        eq_adapt_pkg::tap_word_t t;
        logic [9:0] sel;
        h_low = 1'b0;
        v_low = 1'b0;
        wr = 1'b0;
        t = 8'sh00;
        sel = 10'h000;
        s_d = s_q;

        // Interrupt pin of the recovery loop is asynchronous; filtered level moves when stages 2 and 3 agree
        s_d.cdr_sync = {s_q.cdr_sync[1:0], I_CDR_IRQ};
        if (s_q.cdr_sync[1] == s_q.cdr_sync[2]) begin
            s_d.cdr_level = s_q.cdr_sync[2];
        end

        // Register writes
        wr = I_REG_WE;
        sel = reg_select(I_REG_ADDR);
        if (wr && sel[0]) begin
            s_d.fld_check_en = I_REG_WDATA[`BIT_FLD_CHECK_EN]; // R11
            s_d.ppm_check_en = I_REG_WDATA[`BIT_PPM_CHECK_EN]; // R14
        end else if (wr && sel[1]) begin
            s_d.pattern_clk_en = I_REG_WDATA[`BIT_PATTERN_CLK_EN]; // R12
            s_d.pattern_sel = I_REG_WDATA[1:0]; // R12
        end else if (wr && sel[2]) begin
            s_d.mode_res7 = I_REG_WDATA[7];
            s_d.adapt_mode = I_REG_WDATA[6:5]; // R1
            s_d.fom_sel = I_REG_WDATA[4:3]; // R2
        end else if (wr && sel[3]) begin
            s_d.eye_h_thr = I_REG_WDATA[7:4];
            s_d.eye_v_thr = I_REG_WDATA[3:0];
        end else if (wr && sel[4]) begin
            s_d.ho_h_thr = I_REG_WDATA[7:4];
            s_d.ho_v_thr = I_REG_WDATA[3:0];
        end else if (wr && sel[5]) begin
            s_d.low_power_dis = I_REG_WDATA[`BIT_LOW_POWER_DIS];
            s_d.lock_count = I_REG_WDATA[5:4];
            s_d.tap25_max = I_REG_WDATA[3:0];
        end else if (wr && sel[6]) begin
            s_d.req_res76 = I_REG_WDATA[7:6];
            s_d.tap1_max = I_REG_WDATA[4:0];
        end else if (wr && sel[7]) begin
            s_d.irq_res7 = I_REG_WDATA[7];
            s_d.eye_irq_en = I_REG_WDATA[`BIT_EYE_IRQ_EN];
            s_d.irq_res54 = I_REG_WDATA[5:4];
            s_d.irq_res3 = I_REG_WDATA[3];
            s_d.cap_ovr_en = I_REG_WDATA[`BIT_CAP_OVR_EN];
            s_d.cap_range = I_REG_WDATA[1:0];
        end

        // Offset request: done clears it and raises ready; a new request write wins and drops ready
        if (s_q.offset_req && I_OFFSET_DONE) begin
            s_d.offset_req = 1'b0; // R8
            s_d.offset_ready = 1'b1; // R8
        end
        if (wr && sel[6] && I_REG_WDATA[`BIT_OFFSET_REQ]) begin
            s_d.offset_req = 1'b1; // R8
            s_d.offset_ready = 1'b0; // R8
        end

        // Sticky recovery-loop interrupt: cleared by reading its register, a pending event wins
        if (I_REG_RE && sel[1]) begin
            s_d.cdr_irq_seen = 1'b0;
        end
        if (s_q.cdr_level) begin
            s_d.cdr_irq_seen = 1'b1; // R7
        end

        // Status snapshots, not writable
        s_d.leq_status = I_LINEAR_EQUALIZER_STATUS; // R16
        s_d.dfe_status = I_DECISION_FEEDBACK_EQ_STATUS; // R16

        // Eye interrupt as a level
        h_low = I_HORIZONTAL_EYE_OPENING < scaled(s_q.eye_h_thr, 1'b1); // R3
        v_low = I_VERTICAL_EYE_OPENING < scaled(s_q.eye_v_thr, 1'b1); // R4
        s_d.eye_irq = s_q.eye_irq_en && (h_low || v_low); // R15

        // Handoff from linear to feedback adaptation
        s_d.handoff_ok = I_HORIZONTAL_EYE_OPENING >= scaled(s_q.ho_h_thr, 1'b0) // R5
                         && I_VERTICAL_EYE_OPENING >= scaled(s_q.ho_v_thr, 1'b0); // R6

        // Lock with optional qualifiers
        s_d.lock = I_CDR_LOCK_RAW
                   && (!s_q.fld_check_en || I_FREQUENCY_LOCK_DETECTOR_OK) // R11
                   && (!s_q.ppm_check_en || I_FREQUENCY_OFFSET_OK); // R14

        s_d.cap_range_out = s_q.cap_ovr_en ? s_q.cap_range : I_CAP_RANGE_AUTO; // R13

        // Tap magnitude limits
        t = clamp_tap($signed({{2{I_TAP1_RAW[5]}}, I_TAP1_RAW}), s_q.tap1_max); // R9
        s_d.tap1_out = t[5:0];
        for (int i = 0; i < 4; i++) begin
            t = clamp_tap($signed({{3{I_TAP25_RAW[i*5+4]}}, I_TAP25_RAW[i*5 +: 5]}),
                          {1'b0, s_q.tap25_max}); // R10
            s_d.tap25_out[i*5 +: 5] = t[4:0];
        end

        // Register reads; unmapped offsets read zero
        if (I_REG_RE) begin
            if (I_REG_ADDR == `OFS_LOCK_QUAL) begin
                s_d.rdata = {5'h00, s_q.ppm_check_en, s_q.fld_check_en, 1'b0};
            end else if (I_REG_ADDR == `OFS_CDR_IRQ_AND_PATTERN_CTRL) begin
                s_d.rdata = {3'h0, s_q.cdr_irq_seen, s_q.pattern_clk_en, 1'b0, s_q.pattern_sel}; // R7
            end else if (I_REG_ADDR == `OFS_ADAPTATION_MODE_SELECT) begin
                s_d.rdata = {s_q.mode_res7, s_q.adapt_mode, s_q.fom_sel, 3'h0};
            end else if (I_REG_ADDR == `OFS_EYE_INTERRUPT_THRESHOLDS) begin
                s_d.rdata = {s_q.eye_h_thr, s_q.eye_v_thr};
            end else if (I_REG_ADDR == `OFS_HANDOFF_THRESHOLDS) begin
                s_d.rdata = {s_q.ho_h_thr, s_q.ho_v_thr};
            end else if (I_REG_ADDR == `OFS_LOCK_COUNT_AND_TAP_LIMIT) begin
                s_d.rdata = {s_q.offset_ready, s_q.low_power_dis, s_q.lock_count, s_q.tap25_max}; // R8
            end else if (I_REG_ADDR == `OFS_OFFSET_REQUEST_AND_TAP1_LIMIT) begin
                s_d.rdata = {s_q.req_res76, s_q.offset_req, s_q.tap1_max};
            end else if (I_REG_ADDR == `OFS_EYE_IRQ_ENABLE_AND_CAP_RANGE) begin
                s_d.rdata = {s_q.irq_res7, s_q.eye_irq_en, s_q.irq_res54, s_q.irq_res3,
                             s_q.cap_ovr_en, s_q.cap_range};
            end else if (I_REG_ADDR == `OFS_LINEAR_EQ_STATUS) begin
                s_d.rdata = s_q.leq_status; // R16
            end else if (I_REG_ADDR == `OFS_FEEDBACK_EQ_STATUS) begin
                s_d.rdata = s_q.dfe_status; // R16
            end else begin
                s_d.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            s_q <= RST_STATE;
        end else if (I_CE) begin
            s_q <= s_d;
        end
    end

    assign O_REG_RDATA = s_q.rdata;
    assign O_ADAPT_MODE = s_q.adapt_mode; // R1
    assign O_FOM_SEL = s_q.fom_sel; // R2
    assign O_EYE_IRQ = s_q.eye_irq;
    assign O_HANDOFF_OK = s_q.handoff_ok;
    assign O_FREQUENCY_OFFSET_REQ = s_q.offset_req;
    assign O_LOCK = s_q.lock;
    assign O_PATTERN_CLK_EN = s_q.pattern_clk_en;
    assign O_PATTERN_SEL = s_q.pattern_sel;
    assign O_CAP_RANGE = s_q.cap_range_out;
    assign O_LOCK_COUNT = s_q.lock_count;
    assign O_LOW_POWER_DIS = s_q.low_power_dis;
    assign O_TAP1 = s_q.tap1_out;
    assign O_TAP25 = s_q.tap25_out;

endmodule // eq_adapt_regs

// ==== eq_adapt_regs_properties.sv ====
// Purpose: Port-level properties of the equalizer adaptation register bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to the design from the testbench top
`timescale 1ns/1ps
module eq_adapt_regs_checker (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_CE,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WE,
    input wire logic [7:0] I_HORIZONTAL_EYE_OPENING,
    input wire logic [7:0] I_VERTICAL_EYE_OPENING,
    input wire logic I_CDR_LOCK_RAW,
    input wire logic I_OFFSET_DONE,
    input wire logic [1:0] O_ADAPT_MODE,
    input wire logic O_EYE_IRQ,
    input wire logic O_HANDOFF_OK,
    input wire logic O_FREQUENCY_OFFSET_REQ,
    input wire logic O_LOCK,
    input wire logic [5:0] O_TAP1,
    input wire logic [19:0] O_TAP25
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    logic run;
    logic req_wr;
    assign run = I_CE && I_RST_B;
    assign req_wr = I_REG_WE && I_REG_ADDR == 8'h35 && I_REG_WDATA[5];
    // Openings at or above every possible scaled threshold never raise the interrupt
    property p_eye_quiet;
        $past(run) && $past(I_HORIZONTAL_EYE_OPENING) >= 8'h3C && $past(I_VERTICAL_EYE_OPENING) >= 8'h3C |-> !O_EYE_IRQ;
    endproperty
    a_eye_quiet: assert property (p_eye_quiet) else $error("eye irq with wide openings");
    property p_handoff;
        $past(run) && $past(I_HORIZONTAL_EYE_OPENING) >= 8'h1E && $past(I_VERTICAL_EYE_OPENING) >= 8'h1E |-> O_HANDOFF_OK;
    endproperty
    a_handoff: assert property (p_handoff) else $error("handoff missing with wide openings");
    property p_lock_off;
        $past(run) && !$past(I_CDR_LOCK_RAW) |-> !O_LOCK;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock without raw lock");
    property p_tap1;
        O_TAP1 != 6'h20;
    endproperty
    a_tap1: assert property (p_tap1) else $error("tap1 beyond five-bit magnitude");
    property p_tap25;
        O_TAP25[4:0] != 5'h10 && O_TAP25[9:5] != 5'h10 && O_TAP25[14:10] != 5'h10 && O_TAP25[19:15] != 5'h10;
    endproperty
    a_tap25: assert property (p_tap25) else $error("tap2-5 beyond four-bit magnitude");
    property p_req_rise;
        $rose(O_FREQUENCY_OFFSET_REQ) |-> $past(req_wr && I_CE);
    endproperty
    a_req_rise: assert property (p_req_rise) else $error("offset request without write");
    property p_req_done;
        $past(run && O_FREQUENCY_OFFSET_REQ && I_OFFSET_DONE && !req_wr) |-> !O_FREQUENCY_OFFSET_REQ;
    endproperty
    a_req_done: assert property (p_req_done) else $error("offset request not cleared");
    property p_mode;
        $changed(O_ADAPT_MODE) |-> $past(I_CE && I_REG_WE && I_REG_ADDR == 8'h31);
    endproperty
    a_mode: assert property (p_mode) else $error("mode changed without write");
    c_eye: cover property (O_EYE_IRQ);
    c_handoff: cover property (O_HANDOFF_OK);
    c_req_done: cover property ($fell(O_FREQUENCY_OFFSET_REQ));
endmodule // eq_adapt_regs_checker

// ==== eq_adapt_regs_tb.sv ====
// Purpose: Self-checking bench for the equalizer adaptation register bank
// Assumes: Random register and input values from a fixed seed
// Notes: Shadow copies of the registers give the expected values
`timescale 1ns/1ps
module eq_adapt_regs_tb;
    logic I_CLK = 0;
    logic I_RST_B = 0;
    logic I_CE = 1;
    logic [7:0] addr = 0, wdata = 0, h = 0, v = 0, leq = 0, dfe = 0, nh, nv, o_rdata;
    logic we = 0, re = 0, irq = 0, done = 0, raw = 0, frequency_lock_detector = 0, frequency_offset = 0;
    logic [1:0] cap = 0, o_mode, o_fom, o_psel, o_cap, o_lcnt;
    logic o_eye, o_ho, o_req, o_lock, o_pclk, o_lpd;
    logic [5:0] t1 = 0, o_t1;
    logic [19:0] t25 = 0, o_t25;
    logic [31:0] r;
    logic [7:0] sh [0:7];
    localparam logic [7:0] MSK [0:7] = '{8'h06, 8'h0B, 8'hF8, 8'hFF, 8'hFF, 8'h7F, 8'hDF, 8'hFF};
    localparam logic [7:0] RSTV [0:9] = '{8'h06, 8'h00, 8'h40, 8'h11, 8'h88, 8'h3F, 8'h1F, 8'h33, 8'h00, 8'h00};
    int n_errors = 0, comparisons = 0, cycles = 0;
    eq_adapt_regs DUT (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_CE(I_CE), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
        .I_REG_WE(we), .I_REG_RE(re), .O_REG_RDATA(o_rdata), .I_HORIZONTAL_EYE_OPENING(h),
        .I_VERTICAL_EYE_OPENING(v), .I_CDR_IRQ(irq), .I_OFFSET_DONE(done), .I_CDR_LOCK_RAW(raw),
        .I_FREQUENCY_LOCK_DETECTOR_OK(frequency_lock_detector), .I_FREQUENCY_OFFSET_OK(frequency_offset), .I_CAP_RANGE_AUTO(cap),
        .I_LINEAR_EQUALIZER_STATUS(leq), .I_DECISION_FEEDBACK_EQ_STATUS(dfe), .I_TAP1_RAW(t1), .I_TAP25_RAW(t25),
        .O_ADAPT_MODE(o_mode), .O_FOM_SEL(o_fom), .O_EYE_IRQ(o_eye), .O_HANDOFF_OK(o_ho),
        .O_FREQUENCY_OFFSET_REQ(o_req), .O_LOCK(o_lock), .O_PATTERN_CLK_EN(o_pclk), .O_PATTERN_SEL(o_psel),
        .O_CAP_RANGE(o_cap), .O_LOCK_COUNT(o_lcnt), .O_LOW_POWER_DIS(o_lpd), .O_TAP1(o_t1), .O_TAP25(o_t25));
    always #5 I_CLK = ~I_CLK;
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge I_CLK);
        {addr, wdata, we} <= {a, d, 1'b1};
        @(posedge I_CLK);
        we <= 0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge I_CLK);
        {addr, re} <= {a, 1'b1};
        @(posedge I_CLK);
        re <= 0;
        #1 chk(nm, o_rdata, e);
    endtask
    // Saturate a signed tap of width w to plus or minus lim
    function automatic logic [31:0] clamp(input logic [5:0] x, input int lim, input int w);
        int s;
        s = (w == 6) ? int'($signed(x)) : int'($signed(x[4:0]));
        if (s > lim) s = lim;
        if (s < -lim) s = -lim;
        return (w == 6) ? {26'h0, s[5:0]} : {27'h0, s[4:0]};
    endfunction
    initial begin
        void'($urandom(86920));
        repeat (8) @(posedge I_CLK);
        #1 chk("mode_rst", o_mode, 2'b10);
        chk("lcnt_rst", o_lcnt, 2'b11);
        @(posedge I_CLK) I_RST_B <= 1;
        for (int k = 0; k < 10; k++) rdc("reset_value", 8'h2F + k, RSTV[k]);
        $display("test reset done");
        for (int i = 0; i < 20; i++) begin
            r = $urandom;
            for (int k = 0; k < 8; k++) sh[k] = $urandom & MSK[k];
            sh[2][6:3] = {i[1:0], i[1:0]};
            nh = r[7:0];
            nv = r[15:8];
            if (i < 4) {nh, nv} = {2'b00, sh[3][7:4], 2'b00, 2'b00, sh[3][3:0], 2'b00};
            else if (i < 8) {nh, nv} = {3'h0, sh[4][7:4], 1'b0, 3'h0, sh[4][3:0], 1'b0};
            @(posedge I_CLK);
            {h, v, leq, dfe} <= {nh, nv, r[31:16]};
            {raw, frequency_lock_detector, frequency_offset, cap, t1, t25} <= $urandom;
            for (int k = 0; k < 8; k++) wr(8'h2F + k, sh[k]);
            wr(8'h37, ~leq);
            repeat (2) @(posedge I_CLK);
            #1 chk("mode", o_mode, sh[2][6:5]);
            chk("fom", o_fom, sh[2][4:3]);
            chk("eye", o_eye, sh[7][6] && (h < {sh[3][7:4], 2'b00} || v < {sh[3][3:0], 2'b00}));
            chk("handoff", o_ho, h >= {sh[4][7:4], 1'b0} && v >= {sh[4][3:0], 1'b0});
            chk("lock", o_lock, raw && (frequency_lock_detector || !sh[0][1]) && (frequency_offset || !sh[0][2]));
            chk("pattern", {o_pclk, o_psel}, {sh[1][3], sh[1][1:0]});
            chk("cap", o_cap, sh[7][2] ? sh[7][1:0] : cap);
            chk("lcnt_lpd", {o_lpd, o_lcnt}, sh[5][6:4]);
            chk("tap1", o_t1, clamp(t1, sh[6][4:0], 6));
            for (int j = 0; j < 4; j++) chk("tap25", o_t25[5*j +: 5], clamp({1'b0, t25[5*j +: 5]}, sh[5][3:0], 5));
            for (int k = 0; k < 8; k++) rdc("readback", 8'h2F + k, sh[k]);
            rdc("leq", 8'h37, leq);
            rdc("dfe", 8'h38, dfe);
            rdc("unmapped", 8'h50, 8'h00);
        end
        $display("test random done");
        @(posedge I_CLK) I_CE <= 0;
        wr(8'h31, ~sh[2]);
        @(posedge I_CLK) I_CE <= 1;
        rdc("frozen", 8'h31, sh[2]);
        wr(8'h35, 8'h3F);
        #1 chk("req", o_req, 1'b1);
        rdc("not_ready", 8'h34, sh[5]);
        @(posedge I_CLK) done <= 1;
        @(posedge I_CLK) done <= 0;
        #1 chk("req_done", o_req, 1'b0);
        rdc("ready", 8'h34, sh[5] | 8'h80);
        rdc("self_clear", 8'h35, 8'h1F);
        $display("test offset done");
        @(posedge I_CLK) irq <= 1;
        repeat (8) @(posedge I_CLK);
        rdc("cdr_high", 8'h30, sh[1] | 8'h10);
        @(posedge I_CLK) irq <= 0;
        repeat (8) @(posedge I_CLK);
        rdc("cdr_sticky", 8'h30, sh[1] | 8'h10);
        rdc("cdr_clear", 8'h30, sh[1]);
        $display("test cdr done");
        @(posedge I_CLK) I_RST_B <= 0;
        repeat (3) @(posedge I_CLK);
        #1 chk("mode_mid_rst", o_mode, 2'b10);
        @(posedge I_CLK) I_RST_B <= 1;
        rdc("rst_again", 8'h31, 8'h40);
        $display("test reset again done");
        give_verdict();
    end
endmodule // eq_adapt_regs_tb
bind eq_adapt_regs eq_adapt_regs_checker chk_i (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_CE(I_CE),
    .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_REG_WE(I_REG_WE),
    .I_HORIZONTAL_EYE_OPENING(I_HORIZONTAL_EYE_OPENING), .I_VERTICAL_EYE_OPENING(I_VERTICAL_EYE_OPENING),
    .I_CDR_LOCK_RAW(I_CDR_LOCK_RAW), .I_OFFSET_DONE(I_OFFSET_DONE), .O_ADAPT_MODE(O_ADAPT_MODE),
    .O_EYE_IRQ(O_EYE_IRQ), .O_HANDOFF_OK(O_HANDOFF_OK), .O_FREQUENCY_OFFSET_REQ(O_FREQUENCY_OFFSET_REQ),
    .O_LOCK(O_LOCK), .O_TAP1(O_TAP1), .O_TAP25(O_TAP25));
